// ### design/tsw_pkg.sv
// Constants, types and helpers for the TDM serial framing front end.
// Assumes one 40 MHz APB clock; all serial, frame and test input pins are synchronised inside the top.
package tsw_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RST_MIN_NS = 100;
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NSTR = 16;
    localparam int CMW = 13;
    localparam int MEAS_W = 14;
    localparam int FIFO_DEPTH = 4;
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_CADDR = 8'h08;
    localparam logic [7:0] REG_CDATA = 8'h0C;
    localparam logic [7:0] REG_MEAS = 8'h10;
    localparam logic [1:0] REG_OFS_PAGE = 2'h1;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [1:0] RATE_2M = 2'h0;
    localparam logic [1:0] RATE_4M = 2'h1;
    localparam logic [1:0] RATE_8M = 2'h2;
    localparam int CM_HIZ = 12;
    localparam int CM_CDLY = 11;
    localparam int MEAS_VAL = 16;
    localparam int PIN_SCLK = 16;
    localparam int PIN_FP = 17;
    localparam int PIN_FE = 18;
    localparam int PIN_WIDE = 19;
    localparam int PIN_TCK = 20;
    localparam int PIN_TMS = 21;
    localparam int PIN_TDI = 22;
    localparam int PIN_W = 23;
    localparam logic [1:0] IR_CAPTURE = 2'h1;

    typedef enum logic [15:0] {
        TAP_TLR  = 16'h0001,
        TAP_RTI  = 16'h0002,
        TAP_SDR  = 16'h0004,
        TAP_CDR  = 16'h0008,
        TAP_SHDR = 16'h0010,
        TAP_E1DR = 16'h0020,
        TAP_PDR  = 16'h0040,
        TAP_E2DR = 16'h0080,
        TAP_UDR  = 16'h0100,
        TAP_SIR  = 16'h0200,
        TAP_CIR  = 16'h0400,
        TAP_SHIR = 16'h0800,
        TAP_E1IR = 16'h1000,
        TAP_PIR  = 16'h2000,
        TAP_E2IR = 16'h4000,
        TAP_UIR  = 16'h8000
    } tsw_tap_type;

    // Last bit index of a frame; also the wrap mask for positions
    function automatic logic [9:0] last_bit(input logic [1:0] rate);
        case (rate)
            RATE_8M: last_bit = 10'h3FF;
            RATE_4M: last_bit = 10'h1FF;
            default: last_bit = 10'h0FF;
        endcase
    endfunction
endpackage

// ### design/tsw_serial_framing.sv
// FIFO and top level of the TDM serial stream and framing front end.
// Assumes APB master on pclk; serial, frame and test pins are asynchronous.
`timescale 1ns/1ps
module tsw_fifo
#(
    parameter int W = 14,
    parameter int D = 4
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_ff [0:D-1];
    logic [AW:0]  wp_ff;
    logic [AW:0]  rp_ff;
    logic [AW:0]  nxt_wp;
    logic [AW:0]  nxt_rp;
    logic         push;
    logic         pop;

    // Full when pointers differ only in the wrap bit
    always_comb
    begin
        in_ready = !((wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]));
        out_valid = (wp_ff != rp_ff);
        out_data = mem_ff[rp_ff[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        nxt_wp = push ? wp_ff + {{AW{1'b0}}, 1'b1} : wp_ff;
        nxt_rp = pop ? rp_ff + {{AW{1'b0}}, 1'b1} : rp_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
        end
        else
        begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
    end

    // Storage needs no reset; emptiness hides stale words
    always_ff @(posedge pclk)
    begin
        if (push)
            mem_ff[wp_ff[AW-1:0]] <= in_data;
    end
endmodule

module tsw_serial_framing
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [tsw_pkg::NSTR-1:0] serial_in_streams,
    output logic [tsw_pkg::NSTR-1:0]  serial_out_streams,
    output logic [tsw_pkg::NSTR-1:0]  serial_out_oe,
    input  wire logic                 master_clk,
    input  wire logic                 frame_pulse_input,
    input  wire logic                 frame_eval_or_aux_clock,
    input  wire logic                 wide_frame_select,
    input  wire logic                 test_clk,
    input  wire logic                 test_mode_sel,
    input  wire logic                 test_data_in,
    output logic                      test_data_out,
    output logic                      test_data_out_oe
);
    import tsw_pkg::*;

    logic [PIN_W-1:0]   pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic               phase_ff, nxt_phase, idle_ff, nxt_idle, fpl_ff, nxt_fpl;
    logic               bank_ff, nxt_bank, lock_ff, nxt_lock;
    logic [1:0]         run_ff, nxt_run;
    logic [9:0]         bcnt_ff, nxt_bcnt, last;
    logic [15:0][7:0]   rsh_ff, nxt_rsh, txsh_ff, nxt_txsh;
    logic [15:0]        hz_ff, nhz, oe_ff, nxt_oe;
    logic [7:0]         dmem [0:1][0:15][0:127];
    logic [CMW-1:0]     cmem [0:2047];
    logic [7:0]         mode_ff, nxt_mode;
    logic [10:0]        caddr_ff, nxt_caddr;
    logic [15:0][9:0]   ofs_ff, nxt_ofs;
    logic [31:0]        prdata_ff, nxt_prdata, rdval;
    logic               pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic               pend_ff, nxt_pend;
    logic [MEAS_W-1:0]  mval_ff, nxt_mval, mf_out;
    logic               mf_in_ready, mf_out_valid, mf_pop;
    tsw_tap_type        tap_ff, nxt_tap;
    logic [1:0]         ir_ff, nxt_ir;
    logic               byp_ff, nxt_byp, tdo_ff, nxt_tdo, tdoe_ff, nxt_tdoe;
    logic               wide, fp, sclk_rise, fe_rise, samp, idl, frm_start, bit_tick, rx_tick;
    logic               tck_rise, tck_fall, tx_load, setup, acc, wr, rd, mapped;
    logic [9:0]         nb;

    // Frame position of a stream after its programmed offset
    function automatic logic [9:0] fpos(input logic [9:0] b, input logic [9:0] o,
                                         input logic [1:0] r);
        fpos = (b - o) & last_bit(r);
    endfunction

    // TAP next state from the current state and test mode select
    function automatic tsw_tap_type tap_next(input tsw_tap_type s, input logic m);
        case (s)
            TAP_TLR:  tap_next = m ? TAP_TLR : TAP_RTI;
            TAP_RTI:  tap_next = m ? TAP_SDR : TAP_RTI;
            TAP_SDR:  tap_next = m ? TAP_SIR : TAP_CDR;
            TAP_CDR:  tap_next = m ? TAP_E1DR : TAP_SHDR;
            TAP_SHDR: tap_next = m ? TAP_E1DR : TAP_SHDR;
            TAP_E1DR: tap_next = m ? TAP_UDR : TAP_PDR;
            TAP_PDR:  tap_next = m ? TAP_E2DR : TAP_PDR;
            TAP_E2DR: tap_next = m ? TAP_UDR : TAP_SHDR;
            TAP_SIR:  tap_next = m ? TAP_TLR : TAP_CIR;
            TAP_CIR:  tap_next = m ? TAP_E1IR : TAP_SHIR;
            TAP_SHIR: tap_next = m ? TAP_E1IR : TAP_SHIR;
            TAP_E1IR: tap_next = m ? TAP_UIR : TAP_PIR;
            TAP_PIR:  tap_next = m ? TAP_E2IR : TAP_PIR;
            TAP_E2IR: tap_next = m ? TAP_UIR : TAP_SHIR;
            TAP_UDR, TAP_UIR: tap_next = m ? TAP_SDR : TAP_RTI;
            default:  tap_next = TAP_TLR;
        endcase
    endfunction

    // Two-stage synchronisers; third stage only feeds edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
        end
        else
        begin
            pin_s1_ff <= {test_data_in, test_mode_sel, test_clk, wide_frame_select,
                          frame_eval_or_aux_clock, frame_pulse_input, master_clk,
                          serial_in_streams};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    // Edges and frame start; wide mode samples the pulse on the aux clock
    always_comb
    begin
        wide = pin_s2_ff[PIN_WIDE];
        fp = pin_s2_ff[PIN_FP];
        sclk_rise = pin_s2_ff[PIN_SCLK] && !pin_s3_ff[PIN_SCLK];
        fe_rise = pin_s2_ff[PIN_FE] && !pin_s3_ff[PIN_FE];
        tck_rise = pin_s2_ff[PIN_TCK] && !pin_s3_ff[PIN_TCK];
        tck_fall = !pin_s2_ff[PIN_TCK] && pin_s3_ff[PIN_TCK];
        samp = wide ? fe_rise : sclk_rise;
        idl = wide ? 1'b1 : idle_ff;
        frm_start = samp && (fpl_ff == idl) && (fp != idl);
        bit_tick = sclk_rise && phase_ff && !frm_start;
        // Inputs sampled mid-bit, clear of the sender's edge; keeps the last bit
        rx_tick = sclk_rise && !phase_ff && !frm_start;
        last = last_bit(mode_ff[1:0]);
    end

    // Frame timing: format detection, bit phase, bit counter, bank
    always_comb
    begin
        nxt_phase = phase_ff;
        nxt_bcnt = bcnt_ff;
        nxt_run = run_ff;
        nxt_idle = idle_ff;
        nxt_bank = bank_ff;
        nxt_lock = lock_ff;
        nxt_fpl = samp ? fp : fpl_ff;
        // A level held over four clock edges is the idle level
        if (!wide && sclk_rise)
        begin
            if (fp != fpl_ff)
                nxt_run = 2'h0;
            else if (run_ff != 2'h3)
                nxt_run = run_ff + 2'h1;
            else
                nxt_idle = fp;
        end
        if (frm_start)
        begin
            nxt_bcnt = 10'h000;
            nxt_phase = 1'b0;
            nxt_bank = !bank_ff;
            nxt_lock = 1'b1;
        end
        else if (sclk_rise)
        begin
            nxt_phase = !phase_ff;
            if (phase_ff)
                nxt_bcnt = (bcnt_ff >= last) ? 10'h000 : bcnt_ff + 10'h001;
        end
        nb = nxt_bcnt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_ff <= 1'b0;
            bcnt_ff <= '0;
            run_ff <= '0;
            idle_ff <= 1'b1;
            fpl_ff <= 1'b1;
            bank_ff <= 1'b0;
            lock_ff <= 1'b0;
        end
        else
        begin
            phase_ff <= nxt_phase;
            bcnt_ff <= nxt_bcnt;
            run_ff <= nxt_run;
            idle_ff <= nxt_idle;
            fpl_ff <= nxt_fpl;
            bank_ff <= nxt_bank;
            lock_ff <= nxt_lock;
        end
    end

    // Receive shift and transmit reload; every stream works in parallel
    always_comb
    begin
        tx_load = (bit_tick || frm_start) && (nb[2:0] == 3'h0);
        for (int s = 0; s < NSTR; s++)
        begin
            logic [CMW-1:0] ent;
            logic           bk;
            ent = cmem[{4'(s), nb[9:3]}];
            bk = ent[CM_CDLY] ? !nxt_bank : nxt_bank;
            nxt_rsh[s] = rx_tick ? {rsh_ff[s][6:0], pin_s2_ff[s]} : rsh_ff[s];
            nhz[s] = tx_load ? ent[CM_HIZ] : hz_ff[s];
            if (tx_load)
                nxt_txsh[s] = dmem[bk][ent[10:7]][ent[6:0]];
            else if (bit_tick)
                nxt_txsh[s] = {txsh_ff[s][6:0], 1'b0};
            else
                nxt_txsh[s] = txsh_ff[s];
            nxt_oe[s] = nxt_lock && !nhz[s];
            serial_out_streams[s] = txsh_ff[s][7];
        end
        serial_out_oe = oe_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rsh_ff <= '0;
            txsh_ff <= '0;
            hz_ff <= '1;
            oe_ff <= '0;
        end
        else
        begin
            rsh_ff <= nxt_rsh;
            txsh_ff <= nxt_txsh;
            hz_ff <= nhz;
            oe_ff <= nxt_oe;
        end
    end

    // Completed bytes land in the bank of the running frame
    always_ff @(posedge pclk)
    begin
        for (int s = 0; s < NSTR; s++)
        begin
            logic [9:0] p;
            p = fpos(bcnt_ff, ofs_ff[s], mode_ff[1:0]);
            if (rx_tick && p[2:0] == 3'h7)
                dmem[bank_ff][s][p[9:3]] <= {rsh_ff[s][6:0], pin_s2_ff[s]};
        end
        if (wr && paddr == REG_CDATA)
            cmem[caddr_ff] <= pwdata[CMW-1:0];
    end

    // APB slave: zero wait, answer prepared in the setup cycle
    always_comb
    begin
        setup = psel && !penable;
        acc = psel && penable && pready_ff;
        mapped = (paddr[1:0] == 2'h0) && ((paddr[7:6] == REG_OFS_PAGE) ||
                 (paddr <= REG_MEAS));
        wr = acc && pwrite && !pslverr_ff;
        rd = acc && !pwrite;
        case (paddr)
            REG_MODE:  rdval = {24'h000000, mode_ff};
            REG_STAT:  rdval = {28'h0000000, mf_out_valid, wide, idle_ff, lock_ff};
            REG_CADDR: rdval = {21'h000000, caddr_ff};
            REG_CDATA: rdval = {19'h00000, cmem[caddr_ff]};
            REG_MEAS:  rdval = {15'h0000, mf_out_valid, 2'h0, mf_out};
            default:   rdval = mapped ? {22'h000000, ofs_ff[paddr[5:2]]} : 32'h00000000;
        endcase
        nxt_prdata = setup ? rdval : prdata_ff;
        nxt_pready = setup;
        nxt_pslverr = setup && !mapped;
        nxt_mode = (wr && paddr == REG_MODE) ? pwdata[7:0] : mode_ff;
        nxt_ofs = ofs_ff;
        if (wr && paddr[7:6] == REG_OFS_PAGE)
            nxt_ofs[paddr[5:2]] = pwdata[9:0];
        nxt_caddr = caddr_ff;
        if (wr && paddr == REG_CADDR)
            nxt_caddr = pwdata[10:0];
        else if (acc && paddr == REG_CDATA)
            nxt_caddr = caddr_ff + 11'h001;
        // Pop only what the captured read data showed as valid
        mf_pop = rd && paddr == REG_MEAS && prdata_ff[MEAS_VAL];
        prdata = prdata_ff;
        pready = pready_ff;
        pslverr = pslverr_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            mode_ff <= MODE_RST;
            caddr_ff <= '0;
            ofs_ff <= '0;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            mode_ff <= nxt_mode;
            caddr_ff <= nxt_caddr;
            ofs_ff <= nxt_ofs;
        end
    end

    // Offset capture waits while the FIFO is full; newer edges are dropped
    always_comb
    begin
        nxt_pend = pend_ff;
        nxt_mval = mval_ff;
        if (pend_ff)
            nxt_pend = !mf_in_ready;
        else if (!wide && fe_rise)
        begin
            nxt_pend = 1'b1;
            nxt_mval = {mode_ff[7:4], bcnt_ff};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_ff <= 1'b0;
            mval_ff <= '0;
        end
        else
        begin
            pend_ff <= nxt_pend;
            mval_ff <= nxt_mval;
        end
    end

    tsw_fifo #(.W(MEAS_W), .D(FIFO_DEPTH)) u_meas_fifo
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (pend_ff),
        .in_ready  (mf_in_ready),
        .in_data   (mval_ff),
        .out_valid (mf_out_valid),
        .out_ready (mf_pop),
        .out_data  (mf_out)
    );

    // Test access port: moves on test clock rise, drives out on its fall
    always_comb
    begin
        nxt_tap = tck_rise ? tap_next(tap_ff, pin_s2_ff[PIN_TMS]) : tap_ff;
        nxt_ir = ir_ff;
        nxt_byp = byp_ff;
        nxt_tdo = tdo_ff;
        nxt_tdoe = tdoe_ff;
        if (tck_rise && tap_ff == TAP_CIR)
            nxt_ir = IR_CAPTURE;
        if (tck_rise && tap_ff == TAP_SHIR)
            nxt_ir = {pin_s2_ff[PIN_TDI], ir_ff[1]};
        if (tck_rise && tap_ff == TAP_CDR)
            nxt_byp = 1'b0;
        if (tck_rise && tap_ff == TAP_SHDR)
            nxt_byp = pin_s2_ff[PIN_TDI];
        if (tck_fall)
        begin
            nxt_tdo = (tap_ff == TAP_SHIR) ? ir_ff[0] : byp_ff;
            nxt_tdoe = (tap_ff == TAP_SHIR) || (tap_ff == TAP_SHDR);
        end
        test_data_out = tdo_ff;
        test_data_out_oe = tdoe_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tap_ff <= TAP_TLR;
            ir_ff <= IR_CAPTURE;
            byp_ff <= 1'b0;
            tdo_ff <= 1'b0;
            tdoe_ff <= 1'b0;
        end
        else
        begin
            tap_ff <= nxt_tap;
            ir_ff <= nxt_ir;
            byp_ff <= nxt_byp;
            tdo_ff <= nxt_tdo;
            tdoe_ff <= nxt_tdoe;
        end
    end

    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_quiet;
        !wide && sclk_rise && fp == fpl_ff && run_ff == 2'h3;
    endsequence
    sequence s_rti_sel;
        tap_ff == TAP_RTI && tck_rise && pin_s2_ff[PIN_TMS];
    endsequence

    frame_wrap_a:
        assert property (bit_tick && bcnt_ff == last |=> bcnt_ff == 10'h000)
        else $error("bit counter did not wrap at frame end");
    bit_advance_a:
        assert property (bit_tick && bcnt_ff < last |=> bcnt_ff == $past(bcnt_ff) + 10'h001)
        else $error("bit counter did not advance");
    two_edge_bit_a:
        assert property (sclk_rise && !phase_ff && !frm_start |=> phase_ff && $stable(bcnt_ff))
        else $error("bit advanced on a single clock edge");
    auto_format_a:
        assert property (s_quiet |=> idle_ff == $past(fp))
        else $error("idle level not adopted");
    wide_align_a:
        assert property (wide && fe_rise && fpl_ff && !fp |=> bcnt_ff == 10'h000 && !phase_ff)
        else $error("wide pulse did not align frame");
    meas_take_a:
        assert property (!wide && fe_rise && !pend_ff |=> pend_ff && mval_ff[9:0] == $past(bcnt_ff))
        else $error("offset measurement not taken");
    meas_hold_a:
        assert property (pend_ff && !mf_in_ready |=> pend_ff && $stable(mval_ff))
        else $error("measurement lost under back-pressure");
    chan_hiz_a:
        assert property (tx_load && nhz[0] |=> !serial_out_oe[0])
        else $error("high impedance channel still driven");
    reset_float_a:
        assert property (disable iff (1'b0) !presetn |-> serial_out_oe == '0 && !test_data_out_oe)
        else $error("outputs driven during reset");
    tdo_fall_a:
        assert property ($changed(test_data_out) |-> $past(tck_fall))
        else $error("test data out changed off a falling edge");
    tdo_float_a:
        assert property (tck_fall && tap_ff != TAP_SHIR && tap_ff != TAP_SHDR |=> !test_data_out_oe)
        else $error("test data out driven outside scan");
    tms_steer_a:
        assert property (s_rti_sel |=> tap_ff == TAP_SDR)
        else $error("TAP ignored mode select");
    tdi_shift_a:
        assert property (tap_ff == TAP_SHIR && tck_rise |=> ir_ff[1] == $past(pin_s2_ff[PIN_TDI]))
        else $error("test data in not shifted");
endmodule

// ### tb/tsw_backplane.sv
// Backplane partner: free master clock, active-low frame pulse, stream data.
// Assumes the bench's pclk; rate 0 only, four pclk per master clock period.
`timescale 1ns/1ps
module tsw_backplane
(
    input  wire logic   pclk,
    output logic        master_clk,
    output logic        frame_pulse_input,
    output logic [15:0] serial_in_streams
);
    logic [11:0] cnt_ff = 12'h000;
    logic [7:0]  pat;

    // One frame of 256 bits, eight pclk per bit; top bit is frame parity
    always_ff @(posedge pclk)
    begin
        cnt_ff <= cnt_ff + 12'h001;
    end

    // Two master clock periods per bit; pulse low for one period at frame start
    always_comb
    begin
        master_clk = ~cnt_ff[1];
        frame_pulse_input = (cnt_ff[10:2] != 9'h000);
        serial_in_streams = 16'h0000;
        // Byte {stream, channel}; MSB flips on odd frames so delay modes differ
        for (int s = 0; s < 16; s++)
        begin
            pat = {4'(s), cnt_ff[9:6]} ^ {cnt_ff[11], 7'h00};
            serial_in_streams[s] = pat[3'h7 - cnt_ff[5:3]];
        end
    end
endmodule

// ### tb/tsw_serial_framing_test.sv
// Self-checking bench for the TDM serial framing front end.
// Assumes the backplane partner and APB reads noted in a queue.
`timescale 1ns/1ps
module tsw_serial_framing_test;
    import tsw_pkg::*;
    typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} tsw_note_type;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, fe, wfs;
    logic        master_clk, fp, tck, tms, tdi, tdo, tdo_oe, tdo_s, oe_s, fp_old;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] sin, sout, soe;
    logic [9:0]  ofs_val;
    logic [3:0]  tag;
    logic [23:0] obits, oebits;
    int          n_errors = 0;
    int          n_tests = 0;
    tsw_note_type notes[$];

    tsw_serial_framing DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in_streams(sin),
        .serial_out_streams(sout), .serial_out_oe(soe), .master_clk(master_clk),
        .frame_pulse_input(fp), .frame_eval_or_aux_clock(fe), .wide_frame_select(wfs),
        .test_clk(tck), .test_mode_sel(tms), .test_data_in(tdi),
        .test_data_out(tdo), .test_data_out_oe(tdo_oe));
    tsw_backplane peer (.pclk(pclk), .master_clk(master_clk), .frame_pulse_input(fp),
        .serial_in_streams(sin));

    // 40 MHz clock
    initial forever #12.5 pclk = ~pclk;

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task end_sim();
        $display("mismatches %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Setup then access, held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
        begin
            n_errors++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic r);
        notes.push_back('{e, m, r});
        apb(1'b0, a, 32'h0);
    endtask

    // Bounded wait for the falling edge of the frame pulse
    task wait_frame();
        int k;
        k = 0;
        do
        begin
            fp_old = fp;
            @(posedge pclk);
            k++;
        end
        while (!(fp_old && !fp) && k < 3000);
        if (k >= 3000)
        begin
            n_errors++;
            end_sim();
        end
    endtask

    // Slow test clock: low half sampled at its end, where the output has settled
    task tap(input logic ms);
        tck <= 1'b0;
        tms <= ms;
        tdi <= 1'($urandom);
        repeat (8) @(posedge pclk);
        tdo_s = tdo;
        oe_s = tdo_oe;
        tck <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    // Read results are compared in order against the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            tsw_note_type n;
            n = notes.pop_front();
            check("prdata", prdata & n.mask, n.exp);
            check("pslverr", {31'h0, pslverr}, {31'h0, n.err});
        end
    end

    // Hang guard
    initial
    begin
        repeat (90000) @(posedge pclk);
        n_errors++;
        end_sim();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, fe, tck, tdi, wfs} = 8'h00;
        {paddr, pwdata, tms} = 41'h1_0000_0000_00;
        void'($urandom(62));
        repeat (4) @(posedge pclk);
        check("oe_rst", {16'h0, soe}, 32'h0);
        check("tdo_oe_rst", {31'h0, tdo_oe}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(REG_MODE, 32'h0, 32'hFFFF_FFFF, 1'b0);
        rd(8'h14, 32'h0, 32'hFFFF_FFFF, 1'b1);
        tag = 4'($urandom);
        ofs_val = 10'($urandom);
        apb(1'b1, REG_MODE, {24'h0, tag, 2'h0, RATE_2M});
        rd(REG_MODE, {24'h0, tag, 4'h0}, 32'hFFFF_FFFF, 1'b0);
        apb(1'b1, 8'h54, {22'h0, ofs_val});
        rd(8'h54, {22'h0, ofs_val}, 32'hFFFF_FFFF, 1'b0);
        apb(1'b1, 8'h4C, 32'h0);
        apb(1'b1, 8'h50, 32'h0);
        apb(1'b1, REG_CADDR, 32'h0);
        apb(1'b1, REG_CDATA, 32'h0185);
        apb(1'b1, REG_CDATA, 32'h1000);
        apb(1'b1, REG_CDATA, 32'h0A06);
        rd(REG_CADDR, 32'h3, 32'h7FF, 1'b0);
        repeat (3) wait_frame();
        repeat (7) @(posedge pclk);
        // Mid-bit samples of out stream 0, channels 0 to 2
        for (int k = 0; k < 24; k++)
        begin
            obits = {obits[22:0], sout[0]};
            oebits = {oebits[22:0], soe[0]};
            repeat (8) @(posedge pclk);
        end
        // Source channel 5 comes later than channel 0: variable delay shows odd frame
        check("ch0", {24'h0, obits[23:16]}, 32'hB5);
        check("oe_ch0", {24'h0, oebits[23:16]}, 32'hFF);
        check("oe_ch1", {24'h0, oebits[15:8]}, 32'h00);
        check("ch2", {24'h0, obits[7:0]}, 32'h46);
        rd(REG_STAT, 32'h3, 32'h7, 1'b0);
        // Six edges: four stored, one waits for room, the last is dropped
        repeat (6)
        begin
            fe <= 1'b1;
            repeat (8) @(posedge pclk);
            fe <= 1'b0;
            repeat (40) @(posedge pclk);
        end
        rd(REG_STAT, 32'h8, 32'h8, 1'b0);
        repeat (5) rd(REG_MEAS, {15'h0, 1'b1, 2'h0, tag, 10'h0}, 32'h0001_3C00, 1'b0);
        rd(REG_MEAS, 32'h0, 32'h0001_0000, 1'b0);
        // Wide mode: the evaluation pin carries the aux clock, no measurements
        wfs <= 1'b1;
        repeat (4) @(posedge pclk);
        repeat (1100)
        begin
            fe <= ~fe;
            repeat (2) @(posedge pclk);
        end
        rd(REG_STAT, 32'h7, 32'hF, 1'b0);
        wfs <= 1'b0;
        repeat (4) @(posedge pclk);
        for (int i = 9; i >= 0; i--)
            tap(1'(10'h3EC >> i));
        tap(1'b0);
        check("tdo_bit0", {30'h0, oe_s, tdo_s}, {30'h0, 1'b1, IR_CAPTURE[0]});
        tap(1'b1);
        check("tdo_bit1", {30'h0, oe_s, tdo_s}, {30'h0, 1'b1, IR_CAPTURE[1]});
        tap(1'b1);
        check("tdo_float", {31'h0, oe_s}, 32'h0);
        end_sim();
    end
endmodule
